// *** tkcf_measure.v ***
// Touch key capacitance-to-frequency measurement module, top level
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tkcf_defs.vh"
module tkcf_measure #(
    parameter REF_DIV = `TKCF_REF_DIV
) (
    input wire clock,
    input wire rst_n,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    input wire [3:0] sense_osc,
    output wire [3:0] osc_enable,
    output wire [3:0] pin_is_touch,
    output wire cf_irq,
    output wire slot_irq
);
    // ==========================================================
    // Registers
    reg [7:0] key_select_control_r;
    reg [7:0] pin_function_control_r;
    reg [7:0] counter_run_control_r;
    reg [3:0] win_ctrl_r;
    reg [15:0] cf_count_r;
    reg [13:0] slot_count_r;
    reg slot_overflow_flag_r;
    reg cf_overflow_flag_r;
    reg slot_run_r;
    reg start_d_r;
    reg slot_irq_r;
    reg cf_irq_r;

    wire cf_counter_on = counter_run_control_r[`TKCF_RUN_CF_ON];
    wire slot_start = counter_run_control_r[`TKCF_RUN_START];
    wire ref_clk_en = counter_run_control_r[`TKCF_RUN_REF_EN];
    wire slot_clear = counter_run_control_r[`TKCF_RUN_SLOT_CLR];
    wire cf_clear = counter_run_control_r[`TKCF_RUN_CF_CLR];
    wire slot_clk_sel = counter_run_control_r[`TKCF_RUN_CLK_SEL];
    wire [1:0] key_sel = key_select_control_r[7:6];
    wire [2:0] slot_window_sel = win_ctrl_r[2:0];

    // ==========================================================
    // Pad facing outputs
    assign osc_enable = pin_function_control_r[7:4];
    assign pin_is_touch = pin_function_control_r[3:0];
    assign cf_irq = cf_irq_r;
    assign slot_irq = slot_irq_r;

    // ==========================================================
    // Oscillator synchronisers
    wire [3:0] osc_rise;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_sync
            tkcf_sync_edge u_sync (
                .clock(clock),
                .rst_n(rst_n),
                .din(sense_osc[g] & osc_enable[g]),
                .rise(osc_rise[g])
            );
        end
    endgenerate

    wire ref_tick;
    tkcf_ref_div #(.DIV(REF_DIV)) u_ref (
        .clock(clock),
        .rst_n(rst_n),
        .enable(ref_clk_en),
        .tick(ref_tick)
    );

    // Measured key and slot time base
    wire sel_rise = osc_rise[key_sel];
    wire slot_tick = slot_clk_sel ? osc_rise[3] : ref_tick;

    // Window length: 64 shifted left by the code
    function [13:0] win_len;
        input [2:0] code;
        begin
            win_len = `TKCF_WIN_BASE << code;
        end
    endfunction
    wire [13:0] win_last = win_len(slot_window_sel) - 14'h0001;
    wire slot_done = slot_run_r & slot_tick & (slot_count_r == win_last);

    // ==========================================================
    // Slot counter
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            start_d_r <= 1'b0;
            slot_run_r <= 1'b0;
            slot_count_r <= 14'h0000;
            slot_irq_r <= 1'b0;
        end else begin
            start_d_r <= slot_start;
            slot_irq_r <= slot_done;
            if (!slot_start) begin
                slot_run_r <= 1'b0;
            end else if (!start_d_r) begin
                slot_run_r <= 1'b1;
            end else if (slot_done) begin
                slot_run_r <= 1'b0;
            end
            if (slot_clear) begin
                slot_count_r <= 14'h0000;
            end else if (slot_start & ~start_d_r) begin
                slot_count_r <= 14'h0000;
            end else if (slot_done) begin
                slot_count_r <= 14'h0000;
            end else if (slot_run_r & slot_tick) begin
                slot_count_r <= slot_count_r + 14'h0001;
            end
        end
    end

    // Slot flag cleared by a new start, set when the window completes
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slot_overflow_flag_r <= 1'b0;
        end else if (slot_done) begin
            slot_overflow_flag_r <= 1'b1;
        end else if (slot_start & ~start_d_r) begin
            slot_overflow_flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // Sixteen-bit count, only inside the window
    wire cf_inc = cf_counter_on & slot_run_r & sel_rise;
    wire cf_wrap = cf_inc & (cf_count_r == 16'hffff);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cf_count_r <= 16'h0000;
            cf_irq_r <= 1'b0;
        end else begin
            cf_irq_r <= cf_wrap;
            if (cf_clear) begin
                cf_count_r <= 16'h0000;
            end else if (cf_inc) begin
                cf_count_r <= cf_count_r + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Register writes
    wire wr_st = wr_en & (addr == `TKCF_REG_WINST);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            key_select_control_r <= `TKCF_RST_BYTE;
            pin_function_control_r <= `TKCF_RST_BYTE;
            counter_run_control_r <= `TKCF_RST_BYTE;
            win_ctrl_r <= 4'h0;
            cf_overflow_flag_r <= 1'b0;
        end else begin
            if (wr_en & (addr == `TKCF_REG_KEYSEL)) begin
                key_select_control_r <= wdata;
            end
            if (wr_en & (addr == `TKCF_REG_PINFN)) begin
                pin_function_control_r <= wdata;
            end
            if (wr_en & (addr == `TKCF_REG_RUN)) begin
                counter_run_control_r <= wdata;
            end
            if (wr_st) begin
                win_ctrl_r <= wdata[3:0];
            end
            // Overflow set beats a software clear in the same cycle
            if (cf_wrap) begin
                cf_overflow_flag_r <= 1'b1;
            end else if (wr_st) begin
                cf_overflow_flag_r <= wdata[`TKCF_ST_CF_OV];
            end
        end
    end

    // ==========================================================
    // Register reads, data one cycle after the strobe
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `TKCF_REG_CNT_HI: rdata <= cf_count_r[15:8];
                `TKCF_REG_CNT_LO: rdata <= cf_count_r[7:0];
                `TKCF_REG_KEYSEL: rdata <= key_select_control_r;
                `TKCF_REG_PINFN: rdata <= pin_function_control_r;
                `TKCF_REG_RUN: rdata <= counter_run_control_r;
                `TKCF_REG_WINST: rdata <= {2'b00, slot_overflow_flag_r,
                    cf_overflow_flag_r, win_ctrl_r};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// *** tkcf_defs.vh ***
// Constants for the touch key capacitance-to-frequency measurement block
//
// Operation
// - Upper eight bits of the sixteen-bit count read back, zero after reset.
// - Lower eight bits of the sixteen-bit count read back, zero after reset.
// - Key select field bits 7..6 choose which of four keys is measured.
// - Control 1 bits 7..4 enable each key's sense oscillator.
// - Control 1 bits 3..0 give each shared pin to touch or I/O.
// - Control 2 bit 7 enables the sixteen-bit count.
// - Rising edge of control 2 bit 5 starts the slot; zero stops it.
// - Slot window completion raises the slot interrupt request.
// - Control 2 bit 4 gates the reference clock.
// - Control 2 bit 3 at one clears the slot counter.
// - Control 2 bit 2 at one clears the sixteen-bit count.
// - Control 2 bit 0 picks reference clock or fourth key oscillator for slot.
// - Control 3 bits 7..6 read-only, writes ignored.
// - Control 3 bit 5 is the read-only slot overflow flag.
// - Control 3 bit 4 is a writable flag set on count overflow.
// - Window field bits 2..0 sets slot length 64 shl code.
// - Sense oscillator cycles are counted during the window and kept.
// - Two independent interrupt requests: count overflow and slot completion.
`ifndef TKCF_DEFS_VH
`define TKCF_DEFS_VH
// ==========================================================
// Register indices
`define TKCF_REG_CNT_HI 3'h0
`define TKCF_REG_CNT_LO 3'h1
`define TKCF_REG_KEYSEL 3'h2
`define TKCF_REG_PINFN 3'h3
`define TKCF_REG_RUN 3'h4
`define TKCF_REG_WINST 3'h5
// ==========================================================
// Field positions
`define TKCF_KSEL_HI 7
`define TKCF_KSEL_LO 6
`define TKCF_RUN_CF_ON 7
`define TKCF_RUN_RSV6 6
`define TKCF_RUN_START 5
`define TKCF_RUN_REF_EN 4
`define TKCF_RUN_SLOT_CLR 3
`define TKCF_RUN_CF_CLR 2
`define TKCF_RUN_RSV1 1
`define TKCF_RUN_CLK_SEL 0
`define TKCF_ST_SLOT_OV 5
`define TKCF_ST_CF_OV 4
`define TKCF_ST_RSV3 3
// ==========================================================
// Reset values and timing
`define TKCF_RST_BYTE 8'h00
`define TKCF_WIN_BASE 14'h0040
`define TKCF_REF_DIV 8
`endif

// *** tkcf_sync_edge.v ***
// Two-stage synchroniser with rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module tkcf_sync_edge (
    input wire clock,
    input wire rst_n,
    input wire din,
    output wire rise
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign rise = s2_r & ~s3_r;
endmodule
`default_nettype wire

// *** tkcf_ref_div.v ***
// Reference tick divider from the system clock
`timescale 1ns/1ps
`default_nettype none
module tkcf_ref_div #(
    parameter DIV = 8
) (
    input wire clock,
    input wire rst_n,
    input wire enable,
    output reg tick
);
    reg [7:0] cnt_r;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
            tick <= 1'b0;
        end else if (!enable) begin
            cnt_r <= 8'h00;
            tick <= 1'b0;
        end else if (cnt_r == DIV[7:0] - 8'h01) begin
            cnt_r <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** tkcf_measure_sva.sv ***
// Checker for the touch key measurement block
`timescale 1ns/1ps
`default_nettype none
module tkcf_measure_sva #(
    parameter REF_DIV = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic [3:0] sense_osc,
    input wire logic [3:0] osc_enable,
    input wire logic [3:0] pin_is_touch,
    input wire logic cf_irq,
    input wire logic slot_irq
);
    logic [7:0] run_sh;
    logic [7:0] ksel_sh;
    // ==========================================================
    // Shadows of control bytes, updated like the registers
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_sh <= 8'h00;
            ksel_sh <= 8'h00;
        end else if (wr_en && addr == 3'h4) begin
            run_sh <= wdata;
        end else if (wr_en && addr == 3'h2) begin
            ksel_sh <= wdata;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Properties
    a_osc_en_map: assert property (
        $past(wr_en && addr == 3'h3) |-> osc_enable == $past(wdata[7:4]))
        else $error("osc enable differs from written byte");
    a_pin_fn_map: assert property (
        $past(wr_en && addr == 3'h3) |-> pin_is_touch == $past(wdata[3:0]))
        else $error("pin function differs from written byte");
    a_pin_hold: assert property (
        !$past(wr_en && addr == 3'h3) |->
        $stable(pin_is_touch) && $stable(osc_enable))
        else $error("pin outputs moved without a write");
    a_keysel_read: assert property (
        $past(rd_en && addr == 3'h2) |-> rdata == ksel_sh)
        else $error("key select read back wrong");
    a_slot_irq_one: assert property (slot_irq |=> !slot_irq)
        else $error("slot request longer than one cycle");
    a_start_gap: assert property (
        (wr_en && addr == 3'h4 && wdata[5] && !run_sh[5]) |=>
        !slot_irq [*8])
        else $error("slot ended too soon after start");
    a_stop_quiet: assert property (
        (!run_sh[5]) [*6] |-> !slot_irq)
        else $error("slot request while stopped");
    a_ref_gate: assert property (
        (!run_sh[4] && !run_sh[0]) [*6] |-> !slot_irq)
        else $error("slot ticked with reference gated");
    a_cf_off: assert property ((!run_sh[7]) [*6] |-> !cf_irq)
        else $error("count overflow while counter off");
endmodule
bind tkcf_measure tkcf_measure_sva #(.REF_DIV(REF_DIV)) chk (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sense_osc(sense_osc),
    .osc_enable(osc_enable), .pin_is_touch(pin_is_touch),
    .cf_irq(cf_irq), .slot_irq(slot_irq)
);
`default_nettype wire

// *** tkcf_osc_model.sv ***
// Behavioural sense oscillators of the four touch pads
`timescale 1ns/1ps
`default_nettype none
module tkcf_osc_model #(
    parameter int P0 = 203,
    parameter int P1 = 251,
    parameter int P2 = 299,
    parameter int P3 = 401
) (
    input wire logic [3:0] osc_enable,
    input wire logic [3:0] pin_is_touch,
    output wire logic [3:0] sense_osc
);
    logic [3:0] s = 4'h0;
    wire logic [3:0] on = osc_enable & pin_is_touch;
    assign sense_osc = s;
    // ==========================================================
    // Periods unrelated to the system clock; disabled pads park low
    always #(P0 / 2.0) s[0] = on[0] & ~s[0];
    always #(P1 / 2.0) s[1] = on[1] & ~s[1];
    always #(P2 / 2.0) s[2] = on[2] & ~s[2];
    always #(P3 / 2.0) s[3] = on[3] & ~s[3];
endmodule
`default_nettype wire

// *** tkcf_measure_tb.sv ***
// Testbench for the touch key measurement block
`timescale 1ns/1ps
`default_nettype none
module tkcf_measure_tb;
    localparam int DIV = 2;
    localparam int P0 = 203;
    localparam int P1 = 251;
    localparam int P2 = 299;
    localparam int P3 = 401;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    wire [7:0] rdata;
    wire [3:0] sense_osc;
    wire [3:0] osc_enable;
    wire [3:0] pin_is_touch;
    wire cf_irq;
    wire slot_irq;
    int n_fail = 0;
    int checks_done = 0;
    int j;
    logic [7:0] d;
    logic [7:0] rsv;
    logic [7:0] st3;
    initial begin
        forever #12.5 clock = ~clock;
    end
    tkcf_measure #(.REF_DIV(DIV)) uut (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sense_osc(sense_osc),
        .osc_enable(osc_enable), .pin_is_touch(pin_is_touch),
        .cf_irq(cf_irq), .slot_irq(slot_irq));
    tkcf_osc_model #(.P0(P0), .P1(P1), .P2(P2), .P3(P3)) pads (
        .osc_enable(osc_enable), .pin_is_touch(pin_is_touch),
        .sense_osc(sense_osc));
    // ==========================================================
    // Register access and comparison
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic check8(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_rng(input string nm, input int lo, hi,
            input logic [15:0] g);
        checks_done++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_fail++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // One window: clear, start, wait for end, read the kept count
    task automatic measure(input logic [1:0] k, input logic cs,
            input logic [2:0] code, input logic on);
        int n;
        int i;
        int per;
        logic [7:0] c;
        logic [7:0] hi;
        per = (k == 2'h0) ? P0 : (k == 2'h1) ? P1 : (k == 2'h2) ? P2 : P3;
        n = cs ? (64 << code) : (64 << code) * DIV * 25 / per;
        c = {on, 3'b001, 3'b000, cs} | rsv;
        wr(3'h2, {k, 6'b011000});
        wr(3'h5, {5'h00, code} | st3);
        wr(3'h4, c | 8'h0c);
        wr(3'h4, c);
        wr(3'h4, c | 8'h20);
        rd(3'h5, d);
        check8("slot flag run", 8'h00, d & 8'h20);
        i = 0;
        while (slot_irq !== 1'b1 && i < 40000) begin
            @(posedge clock);
            i++;
        end
        if (i == 40000) begin
            n_fail++;
            tally_and_finish();
        end
        rd(3'h5, d);
        check8("slot flag", 8'h20, d & 8'h20);
        rd(3'h0, hi);
        rd(3'h1, d);
        check_rng("count", on ? n - 1 : 0, on ? n + 1 : 0, {hi, d});
        wr(3'h4, c);
        $display("test window key %0d code %0d done", k, code);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        for (j = 0; j < 7; j++) begin
            rd(3'(j), d);
            if (j == 4) rsv = d & 8'h42;
            if (j == 5) st3 = d & 8'h08;
            check8("reset", 8'h00, d & (j == 5 ? 8'h37 : j == 4 ? 8'hbd : 8'hff));
        end
        $display("test reset values done");
        wr(3'h3, 8'ha5);
        @(posedge clock);
        check8("pin outputs", 8'ha5, {osc_enable, pin_is_touch});
        rd(3'h3, d);
        check8("pin byte", 8'ha5, d);
        wr(3'h5, 8'hd7 | st3);
        rd(3'h5, d);
        check8("status byte", 8'h17, d & 8'h37);
        wr(3'h4, 8'h9d | rsv);
        rd(3'h4, d);
        check8("run byte", 8'h9d, d & 8'hbd);
        wr(3'h5, st3);
        wr(3'h3, 8'hff);
        $display("test register access done");
        for (j = 0; j < 8; j++) begin
            measure(2'(j), 1'b0, 3'(j), 1'b1);
        end
        measure(2'h3, 1'b1, 3'h0, 1'b1);
        measure(2'h3, 1'b1, 3'h1, 1'b1);
        measure(2'h0, 1'b0, 3'h0, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
